/* File: src/sbs_consts.vh */
`ifndef SBS_CONSTS_VH
`define SBS_CONSTS_VH
// array geometry
`define SBS_ADDR_W     17
`define SBS_DATA_W     32
`define SBS_LANES      4
`define SBS_LANE_W     8
`define SBS_DEPTH      131072
// burst counter
`define SBS_BCNT_W     2
`define SBS_BCNT_ZERO  2'h0
`define SBS_BCNT_ONE   2'h1
`define SBS_LANES_ALL  4'hF
`define SBS_LANES_NONE 4'h0
// output staging buffer
`define SBS_BUF_DEPTH  2
`define SBS_BUF_PTR_W  1
`define SBS_BUF_CNT_W  2
`define SBS_BUF_FULL   2'h2
`endif

/* File: src/sbs_array.v */
`timescale 1ns/10ps
`include "sbs_consts.vh"

// synchronous array with per-lane write enables; read data comes out of a register
module sbs_array (
	input  wire                        i_clk,   // clock
	input  wire [`SBS_ADDR_W-1:0]      i_addr,  // word address
	input  wire                        i_rd,    // read strobe
	input  wire [`SBS_LANES-1:0]       i_we,    // per-lane write enable
	input  wire [`SBS_DATA_W-1:0]      i_wdata, // write data
	output wire [`SBS_DATA_W-1:0]      o_rdata  // registered read data
);

// each lane keeps its own storage and read register, so every memory has one writer
genvar g;
generate
	for (g = 0; g < `SBS_LANES; g = g + 1) begin : g_lane
		reg [`SBS_LANE_W-1:0] mem [0:`SBS_DEPTH-1];
		reg [`SBS_LANE_W-1:0] rd_q;
		always @(posedge i_clk) begin
			if (i_we[g]) begin
				mem[i_addr] <= i_wdata[g*`SBS_LANE_W +: `SBS_LANE_W];
			end
			if (i_rd) begin
				rd_q <= mem[i_addr];
			end
		end
		assign o_rdata[g*`SBS_LANE_W +: `SBS_LANE_W] = rd_q;
	end
endgenerate

endmodule // sbs_array

/* File: src/sbs_sram_ctrl.v */
// Notes on behaviour
// - array holds 128K words of 32 bits in four byte lanes a..d.
// - input registers, output register and a 2-bit burst counter make later addresses.
// - address, data and controls sampled on rising edge; output enable, order, sleep are not.
// - either address strobe starts a burst; the device makes the following addresses.
// - advance sampled low steps the burst count in the selected order.
// - order select low gives linear order, high gives interleaved order.
// - controller strobe aborts burst, loads address, starts read, write or deselect.
// - processor strobe does the same but starts no write, and never deselects while primary enable high.
// - writes are timed inside, starting at the edge that samples them.
// - write qualifier with byte strobes writes only the selected lanes.
// - all-bytes write, or all strobes with qualifier, writes all four lanes.
// - read data pass an output register, adding one pipeline stage.
// - output enable gates the data drivers directly, unclocked.
// - primary enable high ignores processor strobe; controller strobe then deselects.
// - all-bytes write overrides byte strobes and write qualifier.
// - after sleep is removed, stay low power until a read or write; keep data.
`timescale 1ns/10ps
`include "sbs_consts.vh"

module sbs_sram_ctrl (
	input  wire                       i_clk,                        // clock
	input  wire                       i_rst_n,                      // sync reset, low
	input  wire [`SBS_ADDR_W-1:0]     i_word_addr,                  // address, low two = burst bits
	input  wire                       i_controller_addr_strobe_n,   // controller strobe, low
	input  wire                       i_processor_addr_strobe_n,    // processor strobe, low
	input  wire                       i_burst_advance_n,            // advance, low
	input  wire                       i_burst_order_select,         // 0 linear, 1 interleaved
	input  wire                       i_primary_chip_enable_n,      // primary enable, low
	input  wire                       i_depth_enable_high,          // depth enable, high
	input  wire                       i_depth_enable_low_n,         // depth enable, low
	input  wire                       i_all_bytes_write_n,          // global write, low
	input  wire                       i_write_qualifier_n,          // write qualifier, low
	input  wire [`SBS_LANES-1:0]      i_byte_lane_write_n,          // per-lane write, low
	input  wire                       i_output_enable_n,            // output enable, low, unclocked
	input  wire                       i_sleep_request,              // sleep, high, unclocked
	input  wire [`SBS_DATA_W-1:0]     i_data_byte_lanes,            // data pins in
	output wire [`SBS_DATA_W-1:0]     o_data_byte_lanes,            // data pins out
	output wire [`SBS_LANES-1:0]      o_data_byte_lanes_oe,         // per-lane driver enable
	output wire                       o_read_valid,                 // buffered read word present
	input  wire                       i_read_ready,                 // receiver takes read word
	output wire                       o_sleeping                    // low-power state
);

////////////////////////////////////////////////////////////////////////////////
// input register stage unclocked pins bypass it

reg  [`SBS_ADDR_W-1:0] addr_q;
reg                    controller_addr_strobe_q;
reg                    processor_addr_strobe_q;
reg                    adv_q;
reg                    ce_n_q;
reg                    ce2_q;
reg                    ce3_n_q;
reg                    gw_q;
reg                    wq_q;
reg  [`SBS_LANES-1:0]  bw_q;
reg  [`SBS_DATA_W-1:0] wdata_q;
reg                    sampled_q;

always @(posedge i_clk) begin
	if (!i_rst_n) begin
		controller_addr_strobe_q    <= 1'b0;
		processor_addr_strobe_q    <= 1'b0;
		adv_q     <= 1'b0;
		gw_q      <= 1'b0;
		wq_q      <= 1'b0;
		bw_q      <= `SBS_LANES_NONE;
		sampled_q <= 1'b0;
	end else begin
		controller_addr_strobe_q    <= ~i_controller_addr_strobe_n;
		processor_addr_strobe_q    <= ~i_processor_addr_strobe_n;
		adv_q     <= ~i_burst_advance_n;
		gw_q      <= ~i_all_bytes_write_n;
		wq_q      <= ~i_write_qualifier_n;
		bw_q      <= ~i_byte_lane_write_n;
		sampled_q <= 1'b1;
	end
	addr_q  <= i_word_addr;
	ce_n_q  <= i_primary_chip_enable_n;
	ce2_q   <= i_depth_enable_high;
	ce3_n_q <= i_depth_enable_low_n;
	wdata_q <= i_data_byte_lanes;
end

////////////////////////////////////////////////////////////////////////////////
// cycle decode

wire chip_sel   = ~ce_n_q & ce2_q & ~ce3_n_q;
wire processor_addr_strobe_taken = processor_addr_strobe_q & ~ce_n_q;
wire start      = processor_addr_strobe_taken | controller_addr_strobe_q;
wire start_sel  = start & chip_sel;
wire start_desel = start & ~chip_sel;
// a taken processor strobe never starts a write; writes need the controller strobe or no taken strobe
wire [`SBS_LANES-1:0] lane_we_raw =
	gw_q ? `SBS_LANES_ALL : (wq_q ? bw_q : `SBS_LANES_NONE);
wire wr_cycle   = ~processor_addr_strobe_taken & (lane_we_raw != `SBS_LANES_NONE);

////////////////////////////////////////////////////////////////////////////////
// burst state and 2-bit counter

reg                    active_q;
reg                    sleep_q;
reg  [`SBS_ADDR_W-1:0] base_q;
reg  [`SBS_BCNT_W-1:0] cnt_q;
reg  [`SBS_BCNT_W-1:0] cnt_d;
reg                    active_d;

always @* begin
	cnt_d    = cnt_q;
	active_d = active_q;
	if (start_sel) begin
		cnt_d    = `SBS_BCNT_ZERO;
		active_d = 1'b1;
	end else if (start_desel) begin
		active_d = 1'b0;
	end else if (active_q && adv_q) begin
		cnt_d = cnt_q + `SBS_BCNT_ONE;
	end // advance high holds cnt_q
end

always @(posedge i_clk) begin
	if (!i_rst_n) begin
		active_q <= 1'b0;
		cnt_q    <= `SBS_BCNT_ZERO;
		base_q   <= {`SBS_ADDR_W{1'b0}};
	end else begin
		active_q <= active_d;
		cnt_q    <= cnt_d;
		if (start_sel) begin
			base_q <= addr_q;
		end
	end
end

// linear adds offset to start bits, interleaved xors them
wire [`SBS_BCNT_W-1:0] start_low = start_sel ? addr_q[`SBS_BCNT_W-1:0] : base_q[`SBS_BCNT_W-1:0];
wire [`SBS_BCNT_W-1:0] off       = start_sel ? `SBS_BCNT_ZERO : cnt_d;
wire [`SBS_BCNT_W-1:0] low_bits  = i_burst_order_select ? (start_low ^ off)
                                                        : (start_low + off);
wire [`SBS_ADDR_W-1:0] hi_src    = start_sel ? addr_q : base_q;
wire [`SBS_ADDR_W-1:0] cur_addr  = {hi_src[`SBS_ADDR_W-1:`SBS_BCNT_W], low_bits};

////////////////////////////////////////////////////////////////////////////////
// sleep: held low power until a read or write command arrives

// a deselecting strobe ends the burst without an access; a selected strobe also wakes
wire access  = sampled_q & (start_sel | (active_q & ~start & ~sleep_q));
wire cmd_in  = sampled_q & start_sel;

always @(posedge i_clk) begin
	if (!i_rst_n) begin
		sleep_q <= 1'b0;
	end else if (i_sleep_request) begin
		sleep_q <= 1'b1;
	end else if (cmd_in) begin
		sleep_q <= 1'b0;
	end
end

// in sleep the array sees no strobes, so contents survive
wire                  do_write = access & wr_cycle & ~i_sleep_request;
wire                  do_read  = access & ~wr_cycle & ~i_sleep_request;
wire [`SBS_LANES-1:0] lane_we  = do_write ? lane_we_raw : `SBS_LANES_NONE;

////////////////////////////////////////////////////////////////////////////////
// array and read pipeline

wire [`SBS_DATA_W-1:0] arr_rdata;
reg                    rd_pend_q;

sbs_array u_array (
	.i_clk   (i_clk),
	.i_addr  (cur_addr),
	.i_rd    (do_read),
	.i_we    (lane_we),
	.i_wdata (wdata_q),
	.o_rdata (arr_rdata)
);

always @(posedge i_clk) begin
	if (!i_rst_n) begin
		rd_pend_q <= 1'b0;
	end else begin
		rd_pend_q <= do_read;
	end
end

// two-entry buffer acts as output register; a word arriving while it is full and not popped is dropped
reg [`SBS_DATA_W-1:0]   buf_q [0:`SBS_BUF_DEPTH-1];
reg [`SBS_BUF_PTR_W-1:0] wp_q;
reg [`SBS_BUF_PTR_W-1:0] rp_q;
reg [`SBS_BUF_CNT_W-1:0] cnt_buf_q;

// a pop in the same cycle frees the slot, so a full buffer still takes the word
wire buf_push = rd_pend_q && ((cnt_buf_q != `SBS_BUF_FULL) || buf_pop);
wire buf_pop  = o_read_valid && i_read_ready;

always @(posedge i_clk) begin
	if (!i_rst_n) begin
		wp_q      <= {`SBS_BUF_PTR_W{1'b0}};
		rp_q      <= {`SBS_BUF_PTR_W{1'b0}};
		cnt_buf_q <= {`SBS_BUF_CNT_W{1'b0}};
	end else begin
		if (buf_push) begin
			buf_q[wp_q] <= arr_rdata;
			wp_q        <= wp_q + 1'b1;
		end
		if (buf_pop) begin
			rp_q <= rp_q + 1'b1;
		end
		cnt_buf_q <= cnt_buf_q + {1'b0, buf_push} - {1'b0, buf_pop};
	end
end

assign o_read_valid      = (cnt_buf_q != {`SBS_BUF_CNT_W{1'b0}});
assign o_data_byte_lanes = buf_q[rp_q];
// drivers follow output enable without a clock, only while read data stand
assign o_data_byte_lanes_oe = {`SBS_LANES{o_read_valid & ~i_output_enable_n}};
assign o_sleeping        = sleep_q;

endmodule // sbs_sram_ctrl

/* File: verification/sbs_ctrl_props.sv */
`timescale 1ns/10ps
`include "sbs_consts.vh"
module sbs_ctrl_props (
	input wire                   i_clk,                      // clock
	input wire                   i_rst_n,                    // sync reset, low
	input wire                   i_controller_addr_strobe_n, // strobe
	input wire                   i_processor_addr_strobe_n,  // strobe
	input wire                   i_primary_chip_enable_n,    // enable
	input wire                   i_depth_enable_high,        // enable
	input wire                   i_depth_enable_low_n,       // enable
	input wire                   i_all_bytes_write_n,        // global write
	input wire                   i_write_qualifier_n,        // qualifier
	input wire                   i_output_enable_n,          // driver gate
	input wire                   i_sleep_request,            // sleep
	input wire                   i_read_ready,               // pop
	input wire [`SBS_DATA_W-1:0] o_data_byte_lanes,          // read word
	input wire [`SBS_LANES-1:0]  o_data_byte_lanes_oe,       // drivers
	input wire                   o_read_valid,               // word present
	input wire                   o_sleeping                  // low power
);
	wire c = !i_controller_addr_strobe_n;
	wire en = !i_primary_chip_enable_n && i_depth_enable_high && !i_depth_enable_low_n;
	wire idl = i_controller_addr_strobe_n && i_processor_addr_strobe_n;
	wire nwr = i_all_bytes_write_n && i_write_qualifier_n;
	wire v = o_read_valid;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	AST_OE_GATE: assert property (o_data_byte_lanes_oe == {`SBS_LANES{v && !i_output_enable_n}})
		else $error("driver enable does not follow valid and output enable");
	AST_RD_LAT: assert property (c && en && nwr && !i_sleep_request && !v |-> ##3 v)
		else $error("controller read word late");
	AST_PROC_RD: assert property (!i_processor_addr_strobe_n && en && !i_sleep_request && !v |-> ##3 v)
		else $error("processor read word late");
	AST_HOLD: assert property (v && !i_read_ready |=> v && $stable(o_data_byte_lanes))
		else $error("stalled word changed or lost");
	AST_DESEL: assert property (c && !en && !v ##1 (idl && !v)[*2] |=> !v)
		else $error("deselect produced a read");
	AST_PROC_IGN: assert property (c && !en && !v ##1 (!i_processor_addr_strobe_n && !c &&
		i_primary_chip_enable_n) ##1 (idl && !v)[*2] |=> !v)
		else $error("processor strobe not ignored");
	AST_WR_QUIET: assert property (c && en && !i_all_bytes_write_n && !v ##1 (!v)[*2] |=> !v)
		else $error("write produced a read word");
	AST_SLEEP_STAY: assert property (o_sleeping && !i_sleep_request && idl && $past(idl) &&
		$past(idl, 2) |=> o_sleeping)
		else $error("left low power without a command");
endmodule // sbs_ctrl_props

/* File: verification/sbs_rx_model.sv */
`timescale 1ns/10ps
`include "sbs_consts.vh"
// receiver of read words; a stall holds ready low so the staging buffer must keep words
module sbs_rx_model (
	input  wire                   i_clk,   // clock
	input  wire                   i_stall, // hold ready low
	input  wire                   i_valid, // word present
	input  wire [`SBS_DATA_W-1:0] i_data,  // word
	output reg                    o_ready  // take word
);
	reg [`SBS_DATA_W-1:0] q [$];
	initial o_ready = 1'b0;
	always @(posedge i_clk) begin
		if (o_ready && i_valid === 1'b1)
			q.push_back(i_data);
		o_ready <= !i_stall;
	end
endmodule // sbs_rx_model

/* File: verification/test_sbs_sram_ctrl.sv */
`timescale 1ns/10ps
`include "sbs_consts.vh"
module test_sbs_sram_ctrl;
	reg                    clk = 1'b0, rst_n = 1'b0, c_n = 1'b1, p_n = 1'b1, v_n = 1'b1, burst_order_select = 1'b0;
	reg                    e_n = 1'b0, deh = 1'b1, del_n = 1'b0, gw_n = 1'b1, wq_n = 1'b1;
	reg                    oe_n = 1'b0, zz = 1'b0, stall = 1'b0;
	reg  [`SBS_LANES-1:0]  bl_n = 4'hF;
	reg  [`SBS_ADDR_W-1:0] addr = 17'h0;
	reg  [`SBS_DATA_W-1:0] din = 32'h0;
	wire [`SBS_DATA_W-1:0] dq;
	wire [`SBS_LANES-1:0]  oe;
	wire                   vld, rdy, slp;
	integer                fail_count = 0, comparisons = 0, o, k;
	sbs_sram_ctrl u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_word_addr(addr),
		.i_controller_addr_strobe_n(c_n), .i_processor_addr_strobe_n(p_n),
		.i_burst_advance_n(v_n), .i_burst_order_select(burst_order_select), .i_primary_chip_enable_n(e_n),
		.i_depth_enable_high(deh), .i_depth_enable_low_n(del_n), .i_all_bytes_write_n(gw_n),
		.i_write_qualifier_n(wq_n), .i_byte_lane_write_n(bl_n), .i_output_enable_n(oe_n),
		.i_sleep_request(zz), .i_data_byte_lanes(din), .o_data_byte_lanes(dq),
		.o_data_byte_lanes_oe(oe), .o_read_valid(vld), .i_read_ready(rdy), .o_sleeping(slp));
	sbs_rx_model u_rx (.i_clk(clk), .i_stall(stall), .i_valid(vld), .i_data(dq), .o_ready(rdy));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input [31:0] e, input [31:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
			end
		end
	endtask
	task cmd(input c, input p, input v, input e, input g, input [3:0] b, input [16:0] a,
		input [31:0] d);
		begin
			@(posedge clk);
			c_n <= c;
			p_n <= p;
			v_n <= v;
			e_n <= e;
			gw_n <= g;
			wq_n <= &b;
			bl_n <= b;
			addr <= a;
			din <= d;
		end
	endtask
	// a burst keeps reading on idle strobes, so every access ends with a deselect
	task desel;
		begin
			cmd(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 17'h0, 32'h0);
			cmd(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, 17'h0, 32'h0);
		end
	endtask
	task wr(input g, input [3:0] b, input [16:0] a, input [31:0] d);
		begin
			cmd(1'b0, 1'b1, 1'b1, 1'b0, g, b, a, d);
			desel;
		end
	endtask
	task rd(input [16:0] a);
		begin
			cmd(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, a, 32'h0);
			desel;
		end
	endtask
	task pop(input [31:0] e);
		begin
			repeat (8) @(posedge clk);
			if (u_rx.q.size() > 0)
				chk(e, u_rx.q.pop_front());
			else
				chk(e, 32'hX);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_lanes;
		begin
			wr(1'b0, 4'hF, 17'h5, 32'h11223344);
			wr(1'b1, 4'hA, 17'h5, 32'hAABBCCDD);
			wr(1'b0, 4'hE, 17'h6, 32'h55667788);
			wr(1'b1, 4'h0, 17'h7, 32'h99AABBCC);
			rd(17'h5);
			pop(32'h11BB33DD);
			rd(17'h6);
			pop(32'h55667788);
			rd(17'h7);
			pop(32'h99AABBCC);
		end
	endtask
	task t_burst;
		begin
			for (k = 0; k < 4; k = k + 1)
				wr(1'b0, 4'hF, 17'h8 + k[16:0], 32'hC0DE0000 + k);
			for (o = 0; o < 2; o = o + 1) begin
				burst_order_select <= o[0];
				cmd(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, 17'h9, 32'h0);
				cmd(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'hF, 17'h0, 32'h0);
				cmd(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'hF, 17'h0, 32'h0);
				cmd(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, 17'h0, 32'h0);
				cmd(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'hF, 17'h0, 32'h0);
				desel;
				repeat (8) @(posedge clk);
				chk(5, u_rx.q.size());
				for (k = 0; k < 5; k = k + 1)
					pop(32'hC0DE0000 + (o ? (1 ^ (k - (k > 2))) : ((1 + k - (k > 2)) % 4)));
			end
		end
	endtask
	task t_desel;
		begin
			cmd(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 17'h0, 32'h0);
			cmd(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 17'h5, 32'h0);
			cmd(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, 17'h0, 32'h0);
			cmd(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, 17'h0, 32'h0);
			cmd(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, 17'h5, 32'h0);
			deh <= 1'b0;
			desel;
			cmd(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, 17'h5, 32'h0);
			del_n <= 1'b1;
			desel;
			del_n <= 1'b0;
			deh <= 1'b1;
			repeat (8) @(posedge clk);
			chk(0, u_rx.q.size());
		end
	endtask
	task t_stall_sleep;
		begin
			stall <= 1'b1;
			rd(17'h5);
			rd(17'h6);
			repeat (8) @(posedge clk);
			chk(32'h11BB33DD, dq);
			chk(32'hF, {28'h0, oe});
			oe_n <= 1'b1;
			#1 chk(32'h0, {28'h0, oe});
			oe_n <= 1'b0;
			stall <= 1'b0;
			pop(32'h11BB33DD);
			pop(32'h55667788);
			zz <= 1'b1;
			repeat (4) @(posedge clk);
			zz <= 1'b0;
			repeat (4) @(posedge clk);
			chk(32'h1, {31'h0, slp});
			rd(17'h7);
			pop(32'h99AABBCC);
			chk(32'h0, {31'h0, slp});
		end
	endtask
	task results;
		begin
			$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
			if (fail_count == 0 && comparisons > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		#50000;
		fail_count = fail_count + 1;
		results;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_lanes;
		t_burst;
		t_desel;
		t_stall_sleep;
		results;
	end
endmodule // test_sbs_sram_ctrl
bind sbs_sram_ctrl sbs_ctrl_props u_props (
	.i_clk                      (i_clk),
	.i_rst_n                    (i_rst_n),
	.i_controller_addr_strobe_n (i_controller_addr_strobe_n),
	.i_processor_addr_strobe_n  (i_processor_addr_strobe_n),
	.i_primary_chip_enable_n    (i_primary_chip_enable_n),
	.i_depth_enable_high        (i_depth_enable_high),
	.i_depth_enable_low_n       (i_depth_enable_low_n),
	.i_all_bytes_write_n        (i_all_bytes_write_n),
	.i_write_qualifier_n        (i_write_qualifier_n),
	.i_output_enable_n          (i_output_enable_n),
	.i_sleep_request            (i_sleep_request),
	.i_read_ready               (i_read_ready),
	.o_data_byte_lanes          (o_data_byte_lanes),
	.o_data_byte_lanes_oe       (o_data_byte_lanes_oe),
	.o_read_valid               (o_read_valid),
	.o_sleeping                 (o_sleeping)
);
